/* dv/slwg_glass_model.sv */
// Glass panel model: integrates how long each electrode is driven high.
// Assumes pins change on clk and the bench opens and closes the window.
`timescale 1ns/10ps
module slwg_glass_model
    import slwg_pkg::*;
(
    input wire logic                   clk,
    input wire logic                   arst_n,
    input wire logic [SLWG_NCOM-1:0]   com_pin,
    input wire logic [SLWG_NSEG-1:0]   seg_pin,
    input wire logic                   win,
    output logic [SLWG_NCOM-1:0][15:0] com_cnt,
    output logic [SLWG_NSEG-1:0][15:0] seg_cnt
);
    logic win_q;

    // ==========================================================
    // Count of cycles each electrode is high, restarted when the window opens
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            win_q   <= 1'b0;
            com_cnt <= '0;
            seg_cnt <= '0;
        end else begin
            win_q <= win;
            if (win) begin
                for (int j = 0; j < SLWG_NCOM; j++) begin
                    com_cnt[j] <= (win_q ? com_cnt[j] : 16'h0)
                                  + 16'(com_pin[j]);
                end
                for (int k = 0; k < SLWG_NSEG; k++) begin
                    seg_cnt[k] <= (win_q ? seg_cnt[k] : 16'h0)
                                  + 16'(seg_pin[k]);
                end
            end
        end
    end
endmodule

/* dv/test_slwg_top.sv */
// Self-checking bench of the segment LCD waveform generator.
// Assumes the default sizes and the glass model watching the pins.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module test_slwg_top
    import slwg_pkg::*;
;
    logic                                clk;
    logic                                arst_n;
    logic                                low_freq_clock;
    logic                                hs_mode;
    logic [1:0]                          op_mode;
    logic [1:0]                          bias_sel;
    logic                                type_b;
    logic [2:0]                          com_num_m1;
    logic [SLWG_DIVW-1:0]                sub_div;
    logic [SLWG_NCOM-1:0][SLWG_NSEG-1:0] seg_data;
    logic [SLWG_NCOM-1:0]                com_out;
    logic [SLWG_NSEG-1:0]                seg_out;
    logic                                running;
    logic                                cfg_reject;
    logic [3:0]                          cur_subframe;
    logic                                win;
    logic [SLWG_NCOM-1:0][15:0]          com_cnt;
    logic [SLWG_NSEG-1:0][15:0]          seg_cnt;
    int                                  fails;
    int                                  comparisons;
    int                                  cycles;

    slwg_top dut_u (
        .clk            (clk),
        .arst_n         (arst_n),
        .low_freq_clock (low_freq_clock),
        .hs_mode        (hs_mode),
        .op_mode        (op_mode),
        .bias_sel       (bias_sel),
        .type_b         (type_b),
        .com_num_m1     (com_num_m1),
        .sub_div        (sub_div),
        .seg_data       (seg_data),
        .com_out        (com_out),
        .seg_out        (seg_out),
        .running        (running),
        .cfg_reject     (cfg_reject),
        .cur_subframe   (cur_subframe)
    );

    slwg_glass_model glass_u (
        .clk     (clk),
        .arst_n  (arst_n),
        .com_pin (com_out),
        .seg_pin (seg_out),
        .win     (win),
        .com_cnt (com_cnt),
        .seg_cnt (seg_cnt)
    );

    // ==========================================================
    // Clocks and run limit
    always #20 clk = ~clk;
    always #307 low_freq_clock = ~low_freq_clock;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            fails++;
            stop_test();
        end
    end

    // ==========================================================
    // Helpers
    task automatic stop_test();
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic wrun(input logic v);
        int n;
        n = 0;
        step();
        while (running !== v && n < 4000) begin
            step();
            n++;
        end
    endtask

    // Waits for a fresh start of sub-frame s; n is the whole wait in cycles
    task automatic wsf(input logic [3:0] s, output int n);
        n = 0;
        while (cur_subframe === s && n < 4000) begin
            step();
            n++;
        end
        while (cur_subframe !== s && n < 4000) begin
            step();
            n++;
        end
    endtask

    task automatic start(input logic hs, input logic [1:0] op,
                         input logic [1:0] bs, input logic tb,
                         input logic [2:0] m1, input logic [15:0] c);
        @(posedge clk);
        op_mode <= SLWG_OP_OFF;
        wrun(1'b0);
        @(posedge clk);
        hs_mode    <= hs;
        op_mode    <= op;
        bias_sel   <= bs;
        type_b     <= tb;
        com_num_m1 <= m1;
        sub_div    <= c;
        wrun(1'b1);
        `CHK(running, 1'b1)
    endtask

    // Opens the glass window for len cycles from the start of sub-frame s
    task automatic meas(input logic [3:0] s, input int len);
        int n;
        wsf(s, n);
        @(posedge clk);
        win <= 1'b1;
        repeat (len) @(posedge clk);
        win <= 1'b0;
        #1;
    endtask

    task automatic seq(input int nsf, input int len);
        int n;
        wsf(4'h0, n);
        for (int i = 1; i <= nsf; i++) begin
            wsf(4'(i % nsf), n);
            `CHK(n, len)
        end
    endtask

    function automatic int sx(int f, int k, int o, int x);
        return seg_data[f][k] ? o : x;
    endfunction

    task automatic judge(input int s, input int m, input int a,
                         input int e, input int o, input int f);
        for (int j = 0; j < m; j++)
            `CHK(com_cnt[j], (j == s % m) ? a : e)
        for (int k = 0; k < SLWG_NSEG; k++)
            `CHK(seg_cnt[k], sx(s % m, k, o, f))
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reject();
        @(posedge clk);
        hs_mode  <= 1'b0;
        op_mode  <= SLWG_OP_PWM;
        bias_sel <= SLWG_B_QUART;
        repeat (3) step();
        `CHK({cfg_reject, running}, 2'h2)
        @(posedge clk);
        hs_mode <= 1'b1;
        op_mode <= 2'h3;
        repeat (3) step();
        `CHK({cfg_reject, running}, 2'h2)
    endtask

    task automatic t_timing();
        start(1'b1, SLWG_OP_PWM, SLWG_B_THIRD, 1'b0, 3'h2, 16'h0002);
        seq(3, 12);
        start(1'b1, SLWG_OP_PWM, SLWG_B_THIRD, 1'b1, 3'h2, 16'h0002);
        seq(6, 12);
        start(1'b1, SLWG_OP_DC, SLWG_B_HALF, 1'b0, 3'h7, 16'h0000);
        seq(8, 4);
    endtask

    task automatic t_low();
        int n;
        start(1'b0, SLWG_OP_PWM, SLWG_B_THIRD, 1'b1, 3'h0, 16'h0101);
        wsf(4'h1, n);
        wsf(4'h0, n);
        `CHK(n inside {[120:126]}, 1'b1)
    endtask

    task automatic t_mid();
        int n;
        start(1'b1, SLWG_OP_PWM, SLWG_B_THIRD, 1'b0, 3'h1, 16'h0002);
        wsf(4'h1, n);
        @(posedge clk);
        type_b     <= 1'b1;
        com_num_m1 <= 3'h3;
        wsf(4'h0, n);
        `CHK(n inside {[10:12]}, 1'b1)
        seq(8, 12);
    endtask

    task automatic t_dc();
        int         nf;
        logic [1:0] md;
        for (int i = 0; i < 8; i++) begin
            md = i[2:1];
            nf = (i[0] ? 8 : 4) * 48;
            start(1'b1, (md == 2'h0) ? SLWG_OP_DC : SLWG_OP_PWM,
                  md - 2'h1, i[0], 3'h3, 16'h000B);
            meas(4'h0, nf);
            judge(0, 4, nf / 2, nf / 2, nf / 2, nf / 2);
            `CHK(com_cnt[7:4], 64'h0)
        end
    endtask

    task automatic t_addr();
        int h;
        for (int t = 0; t < 2; t++) begin
            h = 1 - t;
            start(1'b1, SLWG_OP_PWM, SLWG_B_THIRD, t[0], 3'h3, 16'h000B);
            for (int s = 0; s < 4 * (t + 1); s++) begin
                meas(4'(s), 24 * (t + 1));
                if (s < 4) begin
                    judge(s, 4, 48 >> h, 16 >> h, 0, 32 >> h);
                end else begin
                    judge(s, 4, 0, 32, 48, 16);
                end
            end
        end
    endtask

    task automatic t_pins();
        start(1'b1, SLWG_OP_PWM, SLWG_B_HALF, 1'b0, 3'h1, 16'h000B);
        meas(4'h1, 12);
        judge(1, 2, 12, 6, 0, 12);
        start(1'b1, SLWG_OP_DC, SLWG_B_HALF, 1'b0, 3'h3, 16'h000B);
        meas(4'h2, 12);
        judge(2, 4, 12, 12, 0, 12);
        meas(4'h2, 24);
        judge(2, 4, 24, 12, 0, 24);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        clk            = 1'b0;
        arst_n         = 1'b0;
        low_freq_clock = 1'b0;
        hs_mode        = 1'b1;
        op_mode        = SLWG_OP_OFF;
        bias_sel       = SLWG_B_HALF;
        type_b         = 1'b0;
        com_num_m1     = 3'h0;
        sub_div        = 16'h0000;
        win            = 1'b0;
        fails          = 0;
        comparisons    = 0;
        cycles         = 0;
        for (int j = 0; j < SLWG_NCOM; j++) begin
            seg_data[j] = 61'h234_5678_9ABC_DEF1 >> j;
        end
        repeat (5) @(posedge clk);
        `CHK({running, com_out, seg_out}, 70'h0)
        arst_n <= 1'b1;
        t_reject();
        t_timing();
        t_low();
        t_mid();
        t_dc();
        t_addr();
        t_pins();
        stop_test();
    end
endmodule

/* src/slwg_pkg.sv */
// Constants, encodings and types of the segment LCD waveform generator.
// Assumes a single 25 MHz system clock that also serves as peripheral clock.
package slwg_pkg;

    // ==========================================================
    // Sizes and timing
    localparam int          SLWG_NSEG     = 61;
    localparam int          SLWG_NCOM     = 8;
    localparam int          SLWG_DIVW     = 16;
    localparam int          SLWG_LS_DIVW  = 8;
    localparam int          SLWG_CLK_HZ   = 25_000_000;
    localparam int          SLWG_LF_HZ    = 32_000;
    localparam logic [1:0]  SLWG_LAST_Q   = 2'h3;

    // ==========================================================
    // Drive mode and bias encodings
    localparam logic [1:0]  SLWG_OP_OFF   = 2'h0;
    localparam logic [1:0]  SLWG_OP_DC    = 2'h1;
    localparam logic [1:0]  SLWG_OP_PWM   = 2'h2;
    localparam logic [1:0]  SLWG_B_HALF   = 2'h0;
    localparam logic [1:0]  SLWG_B_THIRD  = 2'h1;
    localparam logic [1:0]  SLWG_B_QUART  = 2'h2;

    // ==========================================================
    // Drive levels, in steps of the drive voltage over B
    localparam logic [2:0]  SLWG_LVL_ZERO = 3'h0;
    localparam logic [2:0]  SLWG_LVL_SOFF = 3'h2;
    localparam logic [2:0]  SLWG_LVL_B2   = 3'h2;
    localparam logic [2:0]  SLWG_LVL_B3   = 3'h3;
    localparam logic [2:0]  SLWG_LVL_B4   = 3'h4;
    localparam logic [2:0]  SLWG_INACT_B2 = 3'h1;
    localparam logic [2:0]  SLWG_INACT_B3 = 3'h1;
    localparam logic [2:0]  SLWG_INACT_B4 = 3'h2;

    typedef enum logic {SLWG_IDLE, SLWG_RUN} slwg_state_t;

endpackage

/* src/slwg_pwm_cell.sv */
// One output pin: PWM of a drive level against a shared phase count.
// Assumes phase counts 0..B-1 and level lies in 0..B.
`timescale 1ns/10ps
module slwg_pwm_cell (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [2:0] level,
    input wire logic [2:0] phase,
    output logic           pin
);
    // Level 0 stays low and level B stays high, so logic levels never pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin <= 1'b0;
        end else begin
            pin <= level > phase;
        end
    end
endmodule

/* src/slwg_subframe_timer.sv */
// Sub-frame timer: four quarters of C+1 ticks each.
// Assumes tick is a one-cycle enable and div is stable within a frame.
`timescale 1ns/10ps
module slwg_subframe_timer
    import slwg_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    slwg_timing_if.timer tif
);
    logic [SLWG_DIVW-1:0] cnt;
    logic [1:0]           quarter;

    // ==========================================================
    // Quarter counter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt     <= '0;
            quarter <= 2'h0;
        end else if (tif.restart) begin
            cnt     <= '0;
            quarter <= 2'h0;
        end else if (tif.tick) begin
            if (cnt == tif.div) begin
                cnt     <= '0;
                quarter <= quarter + 2'h1;
            end else begin
                cnt <= cnt + {{(SLWG_DIVW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign tif.quarter = quarter;
    assign tif.sf_end  = tif.tick && !tif.restart && cnt == tif.div &&
                         quarter == SLWG_LAST_Q;

    // ==========================================================
    // Checks
    a_quarter_wrap: assert property (@(posedge clk) disable iff (!arst_n)
        tif.tick && !tif.restart && cnt == tif.div
        |=> cnt == '0 && quarter == $past(quarter) + 2'h1)
        else $error("quarter did not advance after C+1 ticks");
endmodule

/* src/slwg_timing_if.sv */
// Sub-frame timing bundle between the generator and its sub-frame timer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface slwg_timing_if;
    import slwg_pkg::*;
    logic                 tick;
    logic                 restart;
    logic [SLWG_DIVW-1:0] div;
    logic [1:0]           quarter;
    logic                 sf_end;

    modport timer (input tick, input restart, input div,
                   output quarter, output sf_end);
    modport user  (output tick, output restart, output div,
                   input quarter, input sf_end);
endinterface

/* src/slwg_top.sv */
// Segment LCD waveform generator: frames, sub-frames and pin levels.
// Assumes config and display data come from logic on clk; low_freq_clock
// is an asynchronous pin; clk itself serves as the peripheral clock.
`timescale 1ns/10ps
module slwg_top
    import slwg_pkg::*;
#(
    parameter int NSEG = SLWG_NSEG,
    parameter int NCOM = SLWG_NCOM
)(
    input wire logic                       clk,
    input wire logic                       arst_n,
    input wire logic                       low_freq_clock,
    input wire logic                       hs_mode,
    input wire logic [1:0]                 op_mode,
    input wire logic [1:0]                 bias_sel,
    input wire logic                       type_b,
    input wire logic [2:0]                 com_num_m1,
    input wire logic [SLWG_DIVW-1:0]       sub_div,
    input wire logic [NCOM-1:0][NSEG-1:0]  seg_data,
    output logic [NCOM-1:0]                com_out,
    output logic [NSEG-1:0]                seg_out,
    output logic                           running,
    output logic                           cfg_reject,
    output logic [3:0]                     cur_subframe
);
    // ==========================================================
    // Declarations
    slwg_state_t                 state;
    slwg_state_t                 next_state;
    logic [2:0]                  lf_sync;
    logic                        tick;
    logic                        cfg_ok;
    logic                        load_cfg;
    logic                        frame_end;
    logic [1:0]                  c_op;
    logic [1:0]                  c_bias;
    logic                        c_type_b;
    logic [2:0]                  c_m1;
    logic [SLWG_DIVW-1:0]        c_div;
    logic                        c_hs;
    logic [NCOM-1:0][NSEG-1:0]   data_lat;
    logic [3:0]                  sf;
    logic [3:0]                  sf_last;
    logic                        second_half;
    logic [2:0]                  addr;
    logic                        pol_pos;
    logic [2:0]                  b_val;
    logic [2:0]                  inact_lvl;
    logic [2:0]                  phase;
    logic                        run;
    logic [NCOM-1:0]             active_vec;
    logic [2:0]                  com_lvl [NCOM];
    logic [2:0]                  seg_lvl [NSEG];
    logic                        seg_not_logic;

    slwg_timing_if tif ();

    // ==========================================================
    // Tick source
    // Low-speed ticks are rising edges of the synchronised low clock
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lf_sync <= 3'h0;
        end else begin
            lf_sync <= {lf_sync[1:0], low_freq_clock};
        end
    end

    assign tick = c_hs ? 1'b1 : (lf_sync[1] && !lf_sync[2]);

    // ==========================================================
    // Configuration check and frame-boundary loading
    always_comb begin
        cfg_ok = 1'b1;
        if (op_mode == SLWG_OP_OFF || op_mode == 2'h3) begin
            cfg_ok = 1'b0;
        end else if (op_mode == SLWG_OP_PWM) begin
            if (bias_sel == 2'h3) begin
                cfg_ok = 1'b0;
            end else if (bias_sel == SLWG_B_QUART && !hs_mode) begin
                cfg_ok = 1'b0;
            end
        end
    end

    assign run       = state == SLWG_RUN;
    assign frame_end = run && tif.sf_end && sf == sf_last;
    assign load_cfg  = !run || frame_end;

    always_comb begin
        next_state = state;
        case (state)
            SLWG_IDLE: begin
                if (cfg_ok) begin
                    next_state = SLWG_RUN;
                end
            end
            SLWG_RUN: begin
                if (frame_end && !cfg_ok) begin
                    next_state = SLWG_IDLE;
                end
            end
            default: next_state = SLWG_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SLWG_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            c_op     <= SLWG_OP_OFF;
            c_bias   <= SLWG_B_THIRD;
            c_type_b <= 1'b0;
            c_m1     <= 3'h0;
            c_div    <= '0;
            c_hs     <= 1'b0;
            data_lat <= '0;
        end else if (load_cfg) begin
            // Latching data per frame keeps every segment DC balanced
            c_op     <= op_mode;
            c_bias   <= bias_sel;
            c_type_b <= type_b;
            c_m1     <= com_num_m1;
            c_hs     <= hs_mode;
            c_div    <= hs_mode ? sub_div :
                        {{(SLWG_DIVW-SLWG_LS_DIVW){1'b0}},
                         sub_div[SLWG_LS_DIVW-1:0]};
            data_lat <= seg_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_reject <= 1'b0;
        end else begin
            cfg_reject <= op_mode != SLWG_OP_OFF && !cfg_ok;
        end
    end

    // ==========================================================
    // Sub-frame sequencing
    assign tif.tick    = tick;
    assign tif.restart = !run;
    assign tif.div     = c_div;

    slwg_subframe_timer u_timer (
        .clk    (clk),
        .arst_n (arst_n),
        .tif    (tif)
    );

    // Type A ends at M-1, Type B at 2M-1
    assign sf_last = c_type_b ? {c_m1, 1'b1} : {1'b0, c_m1};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sf <= 4'h0;
        end else if (!run || frame_end) begin
            sf <= 4'h0;
        end else if (tif.sf_end) begin
            sf <= sf + 4'h1;
        end
    end

    assign second_half = c_type_b && (sf > {1'b0, c_m1});
    assign addr = second_half ? 3'(sf - {1'b0, c_m1} - 4'h1)
                              : sf[2:0];
    // Type A flips within each sub-frame, Type B between frame halves
    assign pol_pos = c_type_b ? !second_half : !tif.quarter[1];

    // ==========================================================
    // Bias levels and PWM phase
    always_comb begin
        case (c_bias)
            SLWG_B_HALF: begin
                b_val     = SLWG_LVL_B2;
                inact_lvl = SLWG_INACT_B2;
            end
            SLWG_B_QUART: begin
                b_val     = SLWG_LVL_B4;
                inact_lvl = SLWG_INACT_B4;
            end
            default: begin
                b_val     = SLWG_LVL_B3;
                inact_lvl = SLWG_INACT_B3;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 3'h0;
        end else if (!run) begin
            phase <= 3'h0;
        end else if (tick) begin
            phase <= (phase >= b_val - 3'h1) ? 3'h0 : phase + 3'h1;
        end
    end

    // ==========================================================
    // Common levels
    always_comb begin
        for (int j = 0; j < NCOM; j++) begin
            active_vec[j] = run && (3'(j) <= c_m1) && addr == 3'(j);
            com_lvl[j]    = SLWG_LVL_ZERO;
            if (run && 3'(j) <= c_m1) begin
                if (c_op == SLWG_OP_DC) begin
                    if (active_vec[j]) begin
                        com_lvl[j] = pol_pos ? b_val : SLWG_LVL_ZERO;
                    end else begin
                        // Double rate toggle in inactive sub-frames
                        com_lvl[j] = tif.quarter[0] ? SLWG_LVL_ZERO
                                                    : b_val;
                    end
                end else begin
                    com_lvl[j] = active_vec[j] ? b_val : inact_lvl;
                    if (!pol_pos) begin
                        com_lvl[j] = b_val - com_lvl[j];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Segment levels
    always_comb begin
        seg_not_logic = 1'b0;
        for (int k = 0; k < NSEG; k++) begin
            seg_lvl[k] = SLWG_LVL_ZERO;
            if (run) begin
                // On segments oppose the active common, off ones follow it
                if (data_lat[addr][k]) begin
                    seg_lvl[k] = SLWG_LVL_ZERO;
                end else if (c_op == SLWG_OP_DC) begin
                    seg_lvl[k] = b_val;
                end else begin
                    seg_lvl[k] = SLWG_LVL_SOFF;
                end
                if (!pol_pos) begin
                    seg_lvl[k] = b_val - seg_lvl[k];
                end
            end
            if (seg_lvl[k] != SLWG_LVL_ZERO && seg_lvl[k] != b_val) begin
                seg_not_logic = 1'b1;
            end
        end
    end

    // ==========================================================
    // Pin drivers
    for (genvar j = 0; j < NCOM; j++) begin : g_com
        slwg_pwm_cell u_cell (
            .clk    (clk),
            .arst_n (arst_n),
            .level  (com_lvl[j]),
            .phase  (phase),
            .pin    (com_out[j])
        );
    end

    for (genvar k = 0; k < NSEG; k++) begin : g_seg
        slwg_pwm_cell u_cell (
            .clk    (clk),
            .arst_n (arst_n),
            .level  (seg_lvl[k]),
            .phase  (phase),
            .pin    (seg_out[k])
        );
    end

    assign running      = run;
    assign cur_subframe = sf;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_sf_in_frame: assert property (sf <= sf_last)
        else $error("sub-frame index beyond frame length");

    a_typea_end: assert property (
        frame_end && !c_type_b |-> sf == {1'b0, c_m1})
        else $error("type A frame did not end after M sub-frames");

    a_typeb_addr: assert property (
        run && c_type_b && sf > {1'b0, c_m1}
        |-> addr == 3'(sf - {1'b0, c_m1} - 4'h1))
        else $error("type B second half addresses wrong common");

    a_one_active: assert property (run |-> $onehot(active_vec))
        else $error("not exactly one common active");

    a_typeb_flip: assert property (
        run && c_type_b && tif.sf_end && sf == {1'b0, c_m1}
        |=> !pol_pos ##1 1'b1)
        else $error("type B second half not inverted");

    a_quart_ls_off: assert property (
        run |-> !(c_op == SLWG_OP_PWM && c_bias == SLWG_B_QUART && !c_hs))
        else $error("quarter bias running from low-speed clock");

    a_half_seg_logic: assert property (
        run && c_op == SLWG_OP_PWM && c_bias == SLWG_B_HALF
        |-> !seg_not_logic)
        else $error("half bias segment not at a logic level");

    a_cfg_at_frame: assert property (
        $changed(c_type_b) || $changed(c_m1) || $changed(c_op)
        |-> $past(load_cfg))
        else $error("configuration changed inside a frame");

    a_dc_toggle: assert property (
        run && c_op == SLWG_OP_DC && !active_vec[0] && c_m1 != 3'h0
        |-> com_lvl[0] == (tif.quarter[0] ? SLWG_LVL_ZERO : b_val))
        else $error("inactive common not toggling in correlation mode");

    a_hs_tick: assert property (run && c_hs |-> tick)
        else $error("high-speed generator missed a tick");

    c_typea_frame: cover property (frame_end && !c_type_b);
    c_typeb_frame: cover property (frame_end && c_type_b);
    c_dc_frame:    cover property (frame_end && c_op == SLWG_OP_DC);
    c_ls_frame:    cover property (frame_end && !c_hs);
    c_quart_frame: cover property (frame_end && c_bias == SLWG_B_QUART);
endmodule
